// ---- rtl/breaker_control_supervision.sv ----
// Operation
// R1: Position reads 0 indeterminate, 1 open, 2 closed, 3 disturbed.
// R2: Contradicting contacts show disturbed only after the supervision timer expires.
// R3: Single-contact mode uses the closed contact only; never indeterminate or disturbed.
// R4: Close-interlock flag is the OR of all close interlock inputs.
// R5: Open-interlock flag is the OR of all open interlock inputs.
// R6: Success flag when the breaker reaches the requested end position.
// R7: Disturbed flag when a command ends with the breaker disturbed.
// R8: Refuse commands while a trip is pending; raise trip-pending failure.
// R9: Direction flag for open when open, or close when closed.
// R10: Dedicated flag for a close request while an open is pending.
// R11: Not-ready flag when a command arrives without breaker ready.
// R12: Interlocked commands are not executed; interlock flag raised instead.
// R13: Synchronised close abandoned with timeout flag if never in sync.
// R14: Command unsuccessful with withdrawn flag when breaker is removed.
// R15: Close output from manual/external requests, optionally protection close.
// R16: Open output from manual/external requests, optionally protection trip.
// R17: Slow-breaker alarm on slow operation; cleared by its reset input.
// R18: Removed status flag mirrors the removed input.
// R19: Sync source must assert in-sync within the synchronisation time.
// R20: Dwell time adjustable from 0 to 100 s, default 0.
// R21: Command output only when nothing rejects; one failure flag per rejection.
// R22: Supervision flags are sticky until the next command is taken.
module breaker_control_supervision #(
    parameter int unsigned TICK_CYCLES = breaker_pkg::TICK_TIME_NS / breaker_pkg::CLOCK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic                           clock_in,
    input  wire logic                           rstn_in,
    // Register port
    input  wire logic [breaker_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [breaker_pkg::DATA_W-1:0] wdata_in,
    input  wire logic                           wr_in,
    input  wire logic                           rd_in,
    output logic      [breaker_pkg::DATA_W-1:0] rdata_out,
    // Breaker contacts
    input  wire logic                           aux_closed_in,
    input  wire logic                           aux_open_in,
    input  wire logic                           ready_in,
    input  wire logic                           removed_in,
    input  wire logic                           in_sync_in,
    // Interlocks
    input  wire logic [breaker_pkg::IL_N-1:0]   close_interlock_input_in,
    input  wire logic [breaker_pkg::IL_N-1:0]   open_interlock_input_in,
    // Requests
    input  wire logic                           ext_close_in,
    input  wire logic                           ext_open_in,
    input  wire logic                           protection_close_in,
    input  wire logic                           protection_trip_request_in,
    input  wire logic                           trip_acknowledge_in,
    input  wire logic                           slow_breaker_alarm_reset_in,
    // Drive and status
    output logic                                close_cmd_out,
    output logic                                open_cmd_out,
    output logic      [1:0]                     position_out,
    output logic                                close_interlock_flag_out,
    output logic                                open_interlock_flag_out,
    output logic                                removed_flag_out,
    output logic                                slow_breaker_alarm_out,
    // Supervision flags
    output logic                                cmd_success_flag_out,
    output logic                                cmd_disturbed_flag_out,
    output logic                                cmd_trip_pending_fail_out,
    output logic                                cmd_direction_fail_out,
    output logic                                close_during_open_fail_out,
    output logic                                cmd_not_ready_fail_out,
    output logic                                cmd_interlock_fail_out,
    output logic                                cmd_sync_timeout_fail_out,
    output logic                                cmd_withdrawn_fail_out
);
    import breaker_pkg::*;

    logic                 tick;
    logic [CTRL_W-1:0]    ctrl_q;
    logic [TMR_W-1:0]     disturb_t_q;
    logic [TMR_W-1:0]     sync_t_q;
    logic [TMR_W-1:0]     move_t_q;
    logic [TMR_W-1:0]     dwell_t_q;
    logic [TMR_W-1:0]     dist_cnt_q;
    logic [TMR_W-1:0]     tmr_q;
    logic [TMR_W-1:0]     wr_time;
    logic [1:0]           position_q;
    logic [1:0]           position_d;
    logic [1:0]           target;
    logic [NUM_FLAGS-1:0] ces_q;
    logic [STATUS_W-1:0]  status;
    seq_state_t           state_q;
    logic                 dir_close_q;
    logic                 seq_close_q;
    logic                 seq_open_q;
    logic                 trip_pend_q;
    logic                 ext_close_q;
    logic                 ext_open_q;
    logic                 il_close;
    logic                 il_open;
    logic                 contradiction;
    logic                 dist_expired;
    logic                 cmd_wr;
    logic                 close_req;
    logic                 open_req;
    logic                 any_req;
    logic                 req_close;
    logic                 move_timeout;

    tick_gen #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clock_in (clock_in),
        .rstn_in  (rstn_in),
        .tick_out (tick)
    );

    // Register writes; times are clamped to the 100.00 s ceiling
    assign wr_time = (wdata_in[TMR_W-1:0] > TMR_MAX) ? TMR_MAX : wdata_in[TMR_W-1:0];

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl_q      <= CTRL_RESET;
            disturb_t_q <= DISTURB_T_RESET;
            sync_t_q    <= SYNC_T_RESET;
            move_t_q    <= MOVE_T_RESET;
            dwell_t_q   <= DWELL_T_RESET; // R20
        end else if (wr_in) begin
            case (addr_in)
                ADDR_CTRL:      ctrl_q      <= wdata_in[CTRL_W-1:0];
                ADDR_DISTURB_T: disturb_t_q <= wr_time;
                ADDR_SYNC_T:    sync_t_q    <= wr_time;
                ADDR_MOVE_T:    move_t_q    <= wr_time;
                ADDR_DWELL_T:   dwell_t_q   <= wr_time; // R20
                default:        ;
            endcase
        end
    end

    assign status = {ces_q, (state_q != ST_IDLE), trip_pend_q, slow_breaker_alarm_out,
                     removed_flag_out, open_interlock_flag_out, close_interlock_flag_out, position_q};

    // Unmapped and write-only addresses read as zero
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_out <= '0;
        end else if (rd_in) begin
            case (addr_in)
                ADDR_CTRL:      rdata_out <= {{(DATA_W-CTRL_W){1'b0}}, ctrl_q};
                ADDR_DISTURB_T: rdata_out <= {{(DATA_W-TMR_W){1'b0}}, disturb_t_q};
                ADDR_SYNC_T:    rdata_out <= {{(DATA_W-TMR_W){1'b0}}, sync_t_q};
                ADDR_MOVE_T:    rdata_out <= {{(DATA_W-TMR_W){1'b0}}, move_t_q};
                ADDR_DWELL_T:   rdata_out <= {{(DATA_W-TMR_W){1'b0}}, dwell_t_q};
                ADDR_STATUS:    rdata_out <= {{(DATA_W-STATUS_W){1'b0}}, status};
                default:        rdata_out <= '0;
            endcase
        end else begin
            rdata_out <= '0;
        end
    end

    // Position evaluation
    assign contradiction = (aux_closed_in == aux_open_in);
    assign dist_expired  = (dist_cnt_q >= disturb_t_q);

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dist_cnt_q <= TMR_ZERO;
        end else if (!contradiction) begin
            dist_cnt_q <= TMR_ZERO;
        end else if (tick && !dist_expired) begin
            dist_cnt_q <= dist_cnt_q + 1'b1; // R2
        end
    end

    always_comb begin
        if (ctrl_q[CTRL_SINGLE_BIT]) begin
            position_d = aux_closed_in ? POS_CLOSED : POS_OPEN; // R3
        end else if (!contradiction) begin
            position_d = aux_closed_in ? POS_CLOSED : POS_OPEN; // R1
        end else if (dist_expired) begin
            position_d = POS_DISTURBED; // R2
        end else begin
            position_d = POS_INDETERMINATE; // R1
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            position_q <= POS_INDETERMINATE;
        end else begin
            position_q <= position_d;
        end
    end

    assign position_out = position_q;

    // Plain status mirrors
    assign il_close = |close_interlock_input_in; // R4
    assign il_open  = |open_interlock_input_in; // R5

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            close_interlock_flag_out <= 1'b0;
            open_interlock_flag_out  <= 1'b0;
            removed_flag_out         <= 1'b0;
        end else begin
            close_interlock_flag_out <= il_close; // R4
            open_interlock_flag_out  <= il_open; // R5
            removed_flag_out         <= removed_in; // R18
        end
    end

    // Trip stays pending until acknowledged; a new trip wins over the acknowledge
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            trip_pend_q <= 1'b0;
        end else if (protection_trip_request_in) begin
            trip_pend_q <= 1'b1;
        end else if (trip_acknowledge_in) begin
            trip_pend_q <= 1'b0;
        end
    end

    // Request decode; external inputs are levels, so only their rising edge asks
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ext_close_q <= 1'b0;
            ext_open_q  <= 1'b0;
        end else begin
            ext_close_q <= ext_close_in;
            ext_open_q  <= ext_open_in;
        end
    end

    assign cmd_wr    = wr_in && (addr_in == ADDR_CMD);
    assign open_req  = (cmd_wr && wdata_in[CMD_OPEN_BIT]) || (ext_open_in && !ext_open_q);
    assign close_req = (cmd_wr && wdata_in[CMD_CLOSE_BIT]) || (ext_close_in && !ext_close_q);
    assign any_req   = open_req || close_req;
    // Open wins over a simultaneous close, the safe direction
    assign req_close = close_req && !open_req;
    assign target    = dir_close_q ? POS_CLOSED : POS_OPEN;

    assign move_timeout = (state_q == ST_MOVING) && (position_q != target) &&
                          (position_q != POS_DISTURBED) && !removed_in && (tmr_q == TMR_ZERO);

    // Command sequencer
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_q     <= ST_IDLE;
            dir_close_q <= 1'b0;
            seq_close_q <= 1'b0;
            seq_open_q  <= 1'b0;
            tmr_q       <= TMR_ZERO;
            ces_q       <= '0;
        end else begin
            if (tick && (tmr_q != TMR_ZERO)) begin
                tmr_q <= tmr_q - 1'b1;
            end
            case (state_q)
                ST_IDLE: begin
                    if (any_req) begin
                        ces_q       <= '0; // R22
                        dir_close_q <= req_close;
                        if (removed_in) begin
                            ces_q[F_WITHDRAWN] <= 1'b1; // R14
                        end else if (trip_pend_q) begin
                            ces_q[F_TRIP] <= 1'b1; // R8
                        end else if (position_q == (req_close ? POS_CLOSED : POS_OPEN)) begin
                            ces_q[F_DIR] <= 1'b1; // R9
                        end else if (!ready_in) begin
                            ces_q[F_NOT_READY] <= 1'b1; // R11
                        end else if (req_close ? il_close : il_open) begin
                            ces_q[F_INTERLOCK] <= 1'b1; // R12
                        end else if (req_close && ctrl_q[CTRL_SYNC_BIT]) begin
                            state_q <= ST_SYNC_WAIT;
                            tmr_q   <= sync_t_q;
                        end else begin
                            seq_close_q <= req_close; // R21
                            seq_open_q  <= !req_close; // R21
                            tmr_q       <= move_t_q;
                            state_q     <= ST_MOVING;
                        end
                    end
                end
                ST_SYNC_WAIT: begin
                    if (in_sync_in) begin
                        seq_close_q <= 1'b1;
                        tmr_q       <= move_t_q;
                        state_q     <= ST_MOVING;
                    end else if (tmr_q == TMR_ZERO) begin
                        ces_q[F_SYNC] <= 1'b1; // R13
                        state_q       <= ST_IDLE;
                    end
                end
                ST_MOVING: begin
                    if (close_req && !dir_close_q) begin
                        ces_q <= '0;
                        ces_q[F_CLOSE_OPN] <= 1'b1; // R10
                    end else if (position_q == target) begin
                        ces_q <= NUM_FLAGS'(1) << F_SUCCESS; // R6
                        seq_close_q      <= 1'b0;
                        seq_open_q       <= 1'b0;
                        tmr_q            <= dwell_t_q;
                        state_q          <= ST_DWELL;
                    end else if (position_q == POS_DISTURBED) begin
                        ces_q <= NUM_FLAGS'(1) << F_DISTURBED; // R7
                        seq_close_q        <= 1'b0;
                        seq_open_q         <= 1'b0;
                        state_q            <= ST_IDLE;
                    end else if (removed_in) begin
                        ces_q <= NUM_FLAGS'(1) << F_WITHDRAWN; // R14
                        seq_close_q        <= 1'b0;
                        seq_open_q         <= 1'b0;
                        state_q            <= ST_IDLE;
                    end else if (tmr_q == TMR_ZERO) begin
                        seq_close_q <= 1'b0;
                        seq_open_q  <= 1'b0;
                        state_q     <= ST_IDLE;
                    end
                end
                ST_DWELL: begin
                    if (close_req && !dir_close_q) begin
                        ces_q <= '0;
                        ces_q[F_CLOSE_OPN] <= 1'b1; // R10
                    end
                    if (tmr_q == TMR_ZERO) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Slow operation alarm; a new timeout wins over the reset input
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            slow_breaker_alarm_out <= 1'b0;
        end else if (move_timeout) begin
            slow_breaker_alarm_out <= 1'b1; // R17
        end else if (slow_breaker_alarm_reset_in) begin
            slow_breaker_alarm_out <= 1'b0; // R17
        end
    end

    // Drive outputs, protection terms bypass supervision when enabled
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            close_cmd_out <= 1'b0;
            open_cmd_out  <= 1'b0;
        end else begin
            close_cmd_out <= seq_close_q || (ctrl_q[CTRL_INCL_PROT_BIT] && protection_close_in); // R15
            open_cmd_out  <= seq_open_q || (ctrl_q[CTRL_INCL_TRIP_BIT] && protection_trip_request_in); // R16
        end
    end

    assign cmd_success_flag_out       = ces_q[F_SUCCESS];
    assign cmd_disturbed_flag_out     = ces_q[F_DISTURBED];
    assign cmd_trip_pending_fail_out  = ces_q[F_TRIP];
    assign cmd_direction_fail_out     = ces_q[F_DIR];
    assign close_during_open_fail_out = ces_q[F_CLOSE_OPN];
    assign cmd_not_ready_fail_out     = ces_q[F_NOT_READY];
    assign cmd_interlock_fail_out     = ces_q[F_INTERLOCK];
    assign cmd_sync_timeout_fail_out  = ces_q[F_SYNC];
    assign cmd_withdrawn_fail_out     = ces_q[F_WITHDRAWN];

    default clocking @(posedge clock_in); endclocking
    default disable iff (!rstn_in);

    single_pos_a: assert property (ctrl_q[CTRL_SINGLE_BIT] |=> // R3
        (position_out == POS_OPEN || position_out == POS_CLOSED))
        else $error("single contact mode shows a third position");

    disturb_wait_a: assert property ((position_q == POS_DISTURBED) && !ctrl_q[CTRL_SINGLE_BIT] |-> // R2
        $past(contradiction))
        else $error("disturbed shown without contradicting contacts");

    interlock_or_a: assert property (il_close && !il_open |=> // R4
        close_interlock_flag_out && !open_interlock_flag_out)
        else $error("interlock summary flags disagree with inputs");

    removed_mirror_a: assert property (1'b1 |=> removed_flag_out == $past(removed_in)) // R18
        else $error("removed flag does not follow its input");

    one_failure_a: assert property ($onehot0(ces_q)) // R21
        else $error("more than one supervision flag set");

    trip_refuse_a: assert property ((state_q == ST_IDLE) && any_req && trip_pend_q && !removed_in |=> // R8
        cmd_trip_pending_fail_out && (state_q == ST_IDLE) ##1 !close_cmd_out || ctrl_q[CTRL_INCL_PROT_BIT])
        else $error("command taken while trip pending");

    direction_a: assert property ((state_q == ST_IDLE) && open_req && (position_q == POS_OPEN) &&
        !removed_in && !trip_pend_q |=> cmd_direction_fail_out && !seq_open_q) // R9
        else $error("repeated open not flagged");

    sync_timeout_a: assert property ((state_q == ST_SYNC_WAIT) && !in_sync_in && (tmr_q == TMR_ZERO) |=> // R13
        cmd_sync_timeout_fail_out && (state_q == ST_IDLE) && !seq_close_q)
        else $error("sync timeout not reported");

    success_pos_a: assert property ($rose(cmd_success_flag_out) |-> // R6
        (position_q == target) ##1 (state_q == ST_DWELL || state_q == ST_IDLE))
        else $error("success without end position");

    slow_clear_a: assert property (slow_breaker_alarm_reset_in && !move_timeout |=> !slow_breaker_alarm_out) // R17
        else $error("slow alarm not cleared");
endmodule : breaker_control_supervision

// ---- rtl/breaker_pkg.sv ----
package breaker_pkg;
    // Timing base: all breaker timers count 10 ms ticks
    localparam int unsigned CLOCK_PERIOD_NS = 50;
    localparam int unsigned TICK_TIME_NS    = 10_000_000;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int TMR_W  = 14;
    localparam int IL_N   = 3;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] ADDR_CTRL      = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_CMD       = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_DISTURB_T = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_SYNC_T    = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_MOVE_T    = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_DWELL_T   = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_STATUS    = 8'h18;

    // Control register fields
    localparam int CTRL_W             = 4;
    localparam int CTRL_SINGLE_BIT    = 0;
    localparam int CTRL_INCL_PROT_BIT = 1;
    localparam int CTRL_INCL_TRIP_BIT = 2;
    localparam int CTRL_SYNC_BIT      = 3;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;

    // Command register fields
    localparam int CMD_CLOSE_BIT = 0;
    localparam int CMD_OPEN_BIT  = 1;

    // Timer reset values and upper limit, in ticks
    localparam logic [TMR_W-1:0] DISTURB_T_RESET = 14'h0032;
    localparam logic [TMR_W-1:0] SYNC_T_RESET    = 14'h00C8;
    localparam logic [TMR_W-1:0] MOVE_T_RESET    = 14'h000A;
    localparam logic [TMR_W-1:0] DWELL_T_RESET   = 14'h0000;
    localparam logic [TMR_W-1:0] TMR_MAX         = 14'h2710;
    localparam logic [TMR_W-1:0] TMR_ZERO        = 14'h0000;

    // Position codes
    localparam logic [1:0] POS_INDETERMINATE = 2'h0;
    localparam logic [1:0] POS_OPEN          = 2'h1;
    localparam logic [1:0] POS_CLOSED        = 2'h2;
    localparam logic [1:0] POS_DISTURBED     = 2'h3;

    // Supervision flag indices
    localparam int F_SUCCESS   = 0;
    localparam int F_DISTURBED = 1;
    localparam int F_TRIP      = 2;
    localparam int F_DIR       = 3;
    localparam int F_CLOSE_OPN = 4;
    localparam int F_NOT_READY = 5;
    localparam int F_INTERLOCK = 6;
    localparam int F_SYNC      = 7;
    localparam int F_WITHDRAWN = 8;
    localparam int NUM_FLAGS   = 9;

    // Status register layout: {flags, busy, trip, slow, removed, il_open, il_close, pos}
    localparam int STATUS_W = NUM_FLAGS + 8;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SYNC_WAIT,
        ST_MOVING,
        ST_DWELL
    } seq_state_t;
endpackage : breaker_pkg

// ---- rtl/tick_gen.sv ----
module tick_gen #(
    parameter int unsigned TICK_CYCLES = 200000
) (
    // Clock and reset
    input  wire logic clock_in,
    input  wire logic rstn_in,
    // Tick
    output logic      tick_out
);
    localparam int CNT_W = $clog2(TICK_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TICK_CYCLES - 1);

    logic [CNT_W-1:0] cnt_q;

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_q    <= '0;
            tick_out <= 1'b0;
        end else begin
            tick_out <= (cnt_q == CNT_LAST);
            if (cnt_q == CNT_LAST) begin
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end
endmodule : tick_gen

// ---- verif/breaker_model.sv ----
module breaker_model #(
    parameter int DLY = 8
) (
    input  wire logic clock_in,
    input  wire logic close_cmd_in,
    input  wire logic open_cmd_in,
    output logic      aux_closed_out,
    output logic      aux_open_out,
    output logic      in_sync_out
);
    timeunit 1ns;
    timeprecision 1ns;
    int run = 0;
    // Drive must be held DLY cycles before the contacts move, like a real mechanism
    initial begin
        aux_closed_out = 1'b0;
        aux_open_out   = 1'b1;
    end
    assign in_sync_out = 1'b1;
    always @(posedge clock_in) begin
        run = (close_cmd_in || open_cmd_in) ? run + 1 : 0;
        if (run == DLY) begin
            aux_closed_out <= close_cmd_in && !open_cmd_in;
            aux_open_out   <= open_cmd_in;
        end
    end
endmodule : breaker_model

// ---- verif/breaker_control_supervision_tb.sv ----
module breaker_control_supervision_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import breaker_pkg::*;
    typedef struct {logic [2:0] c, o; logic ec, eo;} row_t;
    logic clock_in = 0, rstn_in = 0, wr_in = 0, rd_in = 0, ready_in = 1, removed_in = 0;
    logic ext_close_in = 0, ext_open_in = 0, protection_trip_request_in = 0, trip_acknowledge_in = 0;
    logic protection_close_in = 0, slow_breaker_alarm_reset_in = 0, in_sync_in, aux_closed_in, aux_open_in;
    logic [7:0] addr_in = 0;
    logic [31:0] wdata_in = 0, rdata_out;
    logic [2:0] close_interlock_input_in = 0, open_interlock_input_in = 0;
    logic close_cmd_out, open_cmd_out, close_interlock_flag_out, open_interlock_flag_out, removed_flag_out;
    logic slow_breaker_alarm_out, cmd_success_flag_out, cmd_disturbed_flag_out, cmd_trip_pending_fail_out;
    logic cmd_direction_fail_out, close_during_open_fail_out, cmd_not_ready_fail_out, cmd_interlock_fail_out;
    logic cmd_sync_timeout_fail_out, cmd_withdrawn_fail_out;
    logic [1:0] position_out;
    logic [8:0] fl;
    int miscompares = 0, n_checks = 0;
    row_t rows[4] = '{'{3'h0, 3'h0, 0, 0}, '{3'h1, 3'h4, 1, 1}, '{3'h2, 3'h0, 1, 0}, '{3'h0, 3'h2, 0, 1}};
    assign fl = {cmd_withdrawn_fail_out, cmd_sync_timeout_fail_out, cmd_interlock_fail_out, cmd_not_ready_fail_out,
                 close_during_open_fail_out, cmd_direction_fail_out, cmd_trip_pending_fail_out,
                 cmd_disturbed_flag_out, cmd_success_flag_out};
    always #25 clock_in = ~clock_in;
    breaker_model #(.DLY(8)) i_brk (.clock_in, .close_cmd_in(close_cmd_out), .open_cmd_in(open_cmd_out),
        .aux_closed_out(aux_closed_in), .aux_open_out(aux_open_in), .in_sync_out(in_sync_in));
    breaker_control_supervision #(.TICK_CYCLES(4)) i_dut (.clock_in, .rstn_in, .addr_in, .wdata_in, .wr_in,
        .rd_in, .rdata_out, .aux_closed_in, .aux_open_in, .ready_in, .removed_in, .in_sync_in,
        .close_interlock_input_in, .open_interlock_input_in, .ext_close_in, .ext_open_in, .protection_close_in,
        .protection_trip_request_in, .trip_acknowledge_in, .slow_breaker_alarm_reset_in, .close_cmd_out,
        .open_cmd_out, .position_out, .close_interlock_flag_out, .open_interlock_flag_out, .removed_flag_out,
        .slow_breaker_alarm_out, .cmd_success_flag_out, .cmd_disturbed_flag_out, .cmd_trip_pending_fail_out,
        .cmd_direction_fail_out, .close_during_open_fail_out, .cmd_not_ready_fail_out, .cmd_interlock_fail_out,
        .cmd_sync_timeout_fail_out, .cmd_withdrawn_fail_out);
    task automatic tick(int n);
        repeat (n) @(posedge clock_in);
    endtask : tick
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One rising edge on the external level is one request
    task automatic req(bit cl);
        @(posedge clock_in);
        if (cl) ext_close_in <= 1; else ext_open_in <= 1;
        tick(1);
        ext_close_in <= 0;
        ext_open_in  <= 0;
        tick(3);
    endtask : req
    task automatic rd(logic [7:0] a, logic [31:0] exp);
        @(posedge clock_in);
        rd_in   <= 1;
        addr_in <= a;
        @(posedge clock_in);
        rd_in <= 0;
        @(negedge clock_in);
        chk(rdata_out, exp);
    endtask : rd
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clock_in);
        {wr_in, addr_in, wdata_in} <= {1'b1, a, d};
        tick(1);
        wr_in <= 0;
    endtask : wr
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : give_verdict
    initial begin
        #1ms;
        miscompares++;
        give_verdict();
    end
    initial begin
        tick(5);
        rstn_in <= 1;
        foreach (rows[i]) begin
            close_interlock_input_in <= rows[i].c;
            open_interlock_input_in  <= rows[i].o;
            tick(3);
            chk({close_interlock_flag_out, open_interlock_flag_out}, {rows[i].ec, rows[i].eo});
        end
        $display("done: interlock table");
        chk(position_out, POS_OPEN);
        close_interlock_input_in <= 3'h4;
        open_interlock_input_in  <= 3'h0;
        req(1);
        chk(fl, 32'(1) << F_INTERLOCK);
        chk(close_cmd_out, 0);
        close_interlock_input_in <= 3'h0;
        req(1);
        for (int i = 0; i < 100 && position_out !== POS_CLOSED; i++) tick(1);
        tick(3);
        chk(fl, 32'(1) << F_SUCCESS);
        chk(position_out, POS_CLOSED);
        req(1);
        chk(fl, 32'(1) << F_DIR);
        ready_in <= 0;
        req(0);
        chk(fl, 32'(1) << F_NOT_READY);
        ready_in   <= 1;
        removed_in <= 1;
        req(0);
        chk(fl, 32'(1) << F_WITHDRAWN);
        chk(removed_flag_out, 1);
        chk(open_cmd_out, 0);
        removed_in <= 0;
        protection_trip_request_in <= 1;
        tick(2);
        req(0);
        chk(fl, 32'(1) << F_TRIP);
        $display("done: rejections");
        rd(ADDR_STATUS, 32'h2 | 32'h40 | (32'(1) << (8 + F_TRIP)));
        rd(8'h40, 32'h0);
        trip_acknowledge_in <= 1;
        protection_trip_request_in <= 0;
        $display("done: status read");
        wr(ADDR_CMD, 32'h2);
        tick(3);
        chk(open_cmd_out, 1);
        tick(12);
        chk(fl, 32'(1) << F_SUCCESS);
        wr(ADDR_MOVE_T, 32'h1);
        req(1);
        tick(5);
        chk(slow_breaker_alarm_out, 1);
        slow_breaker_alarm_reset_in <= 1;
        tick(2);
        chk(slow_breaker_alarm_out, 0);
        wr(ADDR_CTRL, 32'h4);
        protection_trip_request_in <= 1;
        tick(3);
        chk(open_cmd_out, 1);
        rstn_in <= 0;
        tick(2);
        chk({fl, open_cmd_out}, 0);
        rstn_in <= 1;
        $display("done: drive and reset");
        give_verdict();
    end
endmodule : breaker_control_supervision_tb
